// file: src/rx_cell_processor.sv
module rx_cell_processor #(
  parameter int E1_UNIT_CYCLES = rx_cell_pkg::E1_UNIT_CYCLES,
  parameter int T1_UNIT_CYCLES = rx_cell_pkg::T1_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic line_clk,
  input wire logic [7:0] line_data,
  input wire logic cell_rd,
  output logic [7:0] cell_data,
  output logic cell_valid,
  output logic cell_start,
  output logic single_cell_available,
  output logic direct_cell_available,
  output logic irq
);
  // link synchroniser, bit 8 carries the line clock
  logic [8:0] sync1, sync2, sync3;
  logic line_clk_state;
  wire agree = sync2[8] == sync3[8];
  wire byte_stb = agree && sync3[8] && !line_clk_state;
  wire [7:0] rx_byte = sync3[7:0];

  always_ff @(posedge clk) begin
    sync1 <= {line_clk, line_data};
    sync2 <= sync1;
    sync3 <= sync2;
    line_clk_state <= reset ? 1'b0 : (agree ? sync3[8] : line_clk_state);
  end

  // software state
  logic [1:0] port_cfg;
  logic [7:0] period;
  logic [5:0] ctrl;
  logic [1:0] irq_mask;
  logic [1:0] flags;
  logic [7:0] corr_cnt, lat_corr;
  logic [11:0] unc_cnt, lat_unc;
  logic [15:0] acc_cnt, lat_acc;

  // delineation state
  rx_cell_pkg::delin_state_t state;
  logic [39:0] win;
  logic [5:0] pos;
  logic [2:0] good_cnt, bad_cnt;
  logic [3:0] pend_unc;
  logic mode_corr;
  logic [rx_cell_pkg::SCR_LEN-1:0] scr_hist;

  // buffer state
  logic [39:0] hdr_store [4];
  logic [1:0] wr_slot, rd_slot;
  logic [2:0] cell_count;
  logic wr_active;
  logic [5:0] rd_pos;
  logic [7:0] hdr_byte;
  logic sel_hdr;
  logic [7:0] mem_q;

  wire check_byte_offset_en = ctrl[rx_cell_pkg::CTRL_CHECK_BYTE_OFFSET];
  wire corr_en = ctrl[rx_cell_pkg::CTRL_CORR];
  wire descr_en = ctrl[rx_cell_pkg::CTRL_DESCR];
  wire pass_en = ctrl[rx_cell_pkg::CTRL_PASS];
  wire idle_en = ctrl[rx_cell_pkg::CTRL_IDLE];
  wire unas_en = ctrl[rx_cell_pkg::CTRL_UNAS];
  wire poll_sel = port_cfg[rx_cell_pkg::CFG_POLL];

  // header check on the last five bytes
  wire [39:0] next_win = {win[31:0], rx_byte};
  wire [31:0] hdr_word = next_win[39:8];
  wire [7:0] hec_adj = next_win[7:0] ^ (check_byte_offset_en ? rx_cell_pkg::CHECK_BYTE_OFFSET : 8'h00); // [R18]
  wire [7:0] syn = rx_cell_pkg::crc8(hdr_word) ^ hec_adj;
  wire [39:0] fix = rx_cell_pkg::fix_mask(syn);
  wire hec_ok = syn == 8'h00;
  wire correctable = corr_en && mode_corr && !hec_ok && (|fix); // [R19]
  wire good = hec_ok || correctable;
  wire at_hdr = byte_stb && state != rx_cell_pkg::ST_HUNT && pos == rx_cell_pkg::HDR_LAST;
  wire hunt_hit = byte_stb && state == rx_cell_pkg::ST_HUNT && hec_ok;
  wire sync_hdr = at_hdr && state == rx_cell_pkg::ST_SYNC;
  wire leave_sync = sync_hdr && !good && bad_cnt == rx_cell_pkg::ALPHA_LAST; // [R11]

  // cell filtering and buffer admission
  wire is_idle = hdr_word == rx_cell_pkg::IDLE_HDR && hec_ok;
  wire is_unas = hdr_word == rx_cell_pkg::UNAS_HDR && hec_ok;
  wire filtered = (idle_en && is_idle) || (unas_en && is_unas); // [R22]
  wire want_cell = sync_hdr && !leave_sync && (good || pass_en) && !filtered; // [R21]
  wire buf_full = cell_count == rx_cell_pkg::BUF_CELLS;
  wire start_write = want_cell && !buf_full; // [R23]
  wire overrun_evt = want_cell && buf_full; // [R23]

  // counter increments, only from sync headers
  wire corr_inc = (sync_hdr && correctable) || (leave_sync && corr_en); // [R8] [R10]
  wire [3:0] unc_inc = leave_sync ? (corr_en ? rx_cell_pkg::EXIT_UNC_CORR : rx_cell_pkg::EXIT_UNC_DET)
                     : ((sync_hdr && good) ? pend_unc : 4'h0); // [R9] [R10]
  wire acc_inc = start_write; // [R12]

  // payload path and descrambler
  wire in_payload = byte_stb && state != rx_cell_pkg::ST_HUNT && pos >= rx_cell_pkg::HDR_BYTES;
  logic [7:0] dsc_byte;
  logic [rx_cell_pkg::SCR_LEN-1:0] next_hist;

  // self-synchronising x^43+1 over payload bits, msb first
  always_comb begin
    next_hist = scr_hist;
    dsc_byte = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      dsc_byte[i] = rx_byte[i] ^ next_hist[rx_cell_pkg::SCR_LEN-1];
      next_hist = {next_hist[rx_cell_pkg::SCR_LEN-2:0], rx_byte[i]};
    end
  end

  wire [7:0] pay_byte = descr_en ? dsc_byte : rx_byte; // [R20]
  wire mem_we = in_payload && wr_active;
  wire [5:0] wr_off = pos - rx_cell_pkg::HDR_BYTES;
  wire push = mem_we && pos == rx_cell_pkg::CELL_LAST;

  // delineation state machine
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= rx_cell_pkg::ST_HUNT;
      pos <= 6'h00;
      good_cnt <= 3'h0;
      bad_cnt <= 3'h0;
      mode_corr <= 1'b1;
    end else begin
      if (hunt_hit) begin
        pos <= rx_cell_pkg::HDR_BYTES;
      end else if (byte_stb && state != rx_cell_pkg::ST_HUNT) begin
        pos <= (pos == rx_cell_pkg::CELL_LAST) ? 6'h00 : pos + 6'h01;
      end
      case (state)
        rx_cell_pkg::ST_HUNT: begin
          if (hunt_hit) begin
            state <= rx_cell_pkg::ST_PRESYNC;
            good_cnt <= 3'h1;
          end
        end
        rx_cell_pkg::ST_PRESYNC: begin
          if (at_hdr && !hec_ok) begin
            state <= rx_cell_pkg::ST_HUNT;
          end else if (at_hdr) begin
            good_cnt <= good_cnt + 3'h1;
            if (good_cnt + 3'h1 == rx_cell_pkg::DELTA) begin
              state <= rx_cell_pkg::ST_SYNC;
              bad_cnt <= 3'h0;
              mode_corr <= 1'b1;
            end
          end
        end
        rx_cell_pkg::ST_SYNC: begin
          if (leave_sync) begin
            state <= rx_cell_pkg::ST_HUNT; // [R11]
          end else if (sync_hdr) begin
            bad_cnt <= good ? 3'h0 : bad_cnt + 3'h1;
            mode_corr <= hec_ok; // [R19]
          end
        end
        default: begin
          state <= rx_cell_pkg::ST_HUNT;
        end
      endcase
    end
  end

  // header window, descrambler history, errored-run tally
  always_ff @(posedge clk) begin
    if (reset) begin
      win <= 40'h00_0000_0000;
      scr_hist <= '0;
      pend_unc <= 4'h0;
    end else begin
      if (byte_stb) begin
        win <= next_win;
      end
      if (in_payload) begin
        scr_hist <= next_hist; // [R20]
      end
      if (leave_sync || (sync_hdr && good)) begin
        pend_unc <= 4'h0;
      end else if (sync_hdr) begin
        pend_unc <= pend_unc + 4'h1;
      end
    end
  end

  // cell buffer write and read bookkeeping
  wire rd_take = cell_rd && cell_count != 3'h0;
  wire pop = rd_take && rd_pos == rx_cell_pkg::CELL_LAST;
  wire [5:0] rd_off = rd_pos - rx_cell_pkg::HDR_BYTES;
  wire [39:0] rd_hdr = hdr_store[rd_slot];
  wire [7:0] rd_hdr_byte = rd_hdr[8'(39 - 8 * rd_pos) -: 8];

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_slot <= 2'h0;
      rd_slot <= 2'h0;
      cell_count <= 3'h0;
      wr_active <= 1'b0;
      rd_pos <= 6'h00;
      hdr_byte <= 8'h00;
      sel_hdr <= 1'b0;
      cell_valid <= 1'b0;
      cell_start <= 1'b0;
    end else begin
      if (start_write) begin
        hdr_store[wr_slot] <= correctable ? next_win ^ fix : next_win;
        wr_active <= 1'b1;
      end else if (push) begin
        wr_active <= 1'b0;
        wr_slot <= wr_slot + 2'h1;
      end
      cell_count <= cell_count + {2'b00, push} - {2'b00, pop};
      cell_valid <= rd_take;
      cell_start <= rd_take && rd_pos == 6'h00;
      if (rd_take) begin
        hdr_byte <= rd_hdr_byte;
        sel_hdr <= rd_pos < rx_cell_pkg::HDR_BYTES;
        rd_pos <= pop ? 6'h00 : rd_pos + 6'h01;
        rd_slot <= pop ? rd_slot + 2'h1 : rd_slot;
      end
    end
  end

  cell_payload_mem payload_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr({wr_slot, wr_off}),
    .wr_data(pay_byte),
    .rd_addr({rd_slot, rd_off}),
    .rd_data(mem_q)
  );

  assign cell_data = sel_hdr ? hdr_byte : mem_q;
  assign single_cell_available = !poll_sel && cell_count != 3'h0; // [R1]
  assign direct_cell_available = poll_sel && cell_count != 3'h0; // [R1]

  // loss-of-delineation integration
  logic cell_delineation_loss;
  logic [rx_cell_pkg::PRE_W-1:0] pre_cnt;
  logic [7:0] unit_cnt;
  wire out_of_delineation = state != rx_cell_pkg::ST_SYNC;
  wire loss_cond = cell_delineation_loss ? !out_of_delineation : out_of_delineation;
  wire [rx_cell_pkg::PRE_W-1:0] unit_last = port_cfg[rx_cell_pkg::CFG_E1]
      ? rx_cell_pkg::PRE_W'(E1_UNIT_CYCLES - 1) : rx_cell_pkg::PRE_W'(T1_UNIT_CYCLES - 1); // [R5]
  wire unit_done = pre_cnt == unit_last;
  wire loss_toggle = loss_cond && (period == 8'h00 || (unit_done && unit_cnt + 8'h01 == period)); // [R2] [R3] [R4]

  always_ff @(posedge clk) begin
    if (reset) begin
      cell_delineation_loss <= 1'b1;
      pre_cnt <= '0;
      unit_cnt <= 8'h00;
    end else if (!loss_cond || loss_toggle) begin
      cell_delineation_loss <= cell_delineation_loss ^ loss_toggle;
      pre_cnt <= '0;
      unit_cnt <= 8'h00;
    end else begin
      pre_cnt <= unit_done ? '0 : pre_cnt + 1'b1;
      unit_cnt <= unit_done ? unit_cnt + 8'h01 : unit_cnt;
    end
  end

  // bus slave decode
  logic [9:0] aw_addr;
  logic [7:0] w_byte;
  logic aw_got, w_got, w_lane;
  wire [7:0] wr_idx = aw_addr[9:2];
  wire [7:0] rd_idx = araddr[9:2];
  wire do_write = aw_got && w_got && !bvalid;
  wire wr_en = do_write && w_lane;
  wire latch_wr = wr_en && wr_idx == rx_cell_pkg::IDX_LATCH; // [R6]
  wire rd_go = arvalid && arready;
  wire stat_rd = rd_go && rd_idx == rx_cell_pkg::IDX_STATUS;
  wire cell_alias = rd_idx[rx_cell_pkg::ALIAS_BITS-1:0] == rx_cell_pkg::IDX_CELL_HI[rx_cell_pkg::ALIAS_BITS-1:0];
  wire cell_alias_lo = rd_idx[rx_cell_pkg::ALIAS_BITS-1:0] == rx_cell_pkg::IDX_CELL_LO[rx_cell_pkg::ALIAS_BITS-1:0];
  wire wr_hit = wr_idx == rx_cell_pkg::IDX_PORT_CFG || wr_idx == rx_cell_pkg::IDX_PERIOD
      || wr_idx == rx_cell_pkg::IDX_LATCH || wr_idx == rx_cell_pkg::IDX_CTRL || wr_idx == rx_cell_pkg::IDX_IRQ_MASK;
  wire [7:0] status_byte = {2'b00, state == rx_cell_pkg::ST_SYNC, state == rx_cell_pkg::ST_PRESYNC,
                            !mode_corr, cell_delineation_loss, flags}; // [R15] [R16]
  logic [7:0] rd_val;
  logic rd_hit;

  // read mux, latch aliases repeat every 32 indices
  always_comb begin
    rd_hit = 1'b1;
    if (rd_idx == rx_cell_pkg::IDX_PORT_CFG) begin
      rd_val = {6'h00, port_cfg};
    end else if (rd_idx == rx_cell_pkg::IDX_PERIOD) begin
      rd_val = period;
    end else if (rd_idx == rx_cell_pkg::IDX_LATCH) begin
      rd_val = 8'h00;
    end else if (rd_idx == rx_cell_pkg::IDX_CORR) begin
      rd_val = lat_corr;
    end else if (rd_idx == rx_cell_pkg::IDX_UNC_HI) begin
      rd_val = {4'h0, lat_unc[11:8]};
    end else if (rd_idx == rx_cell_pkg::IDX_UNC_LO) begin
      rd_val = lat_unc[7:0];
    end else if (cell_alias) begin
      rd_val = lat_acc[15:8]; // [R7]
    end else if (cell_alias_lo) begin
      rd_val = lat_acc[7:0]; // [R7]
    end else if (rd_idx == rx_cell_pkg::IDX_STATUS) begin
      rd_val = status_byte;
    end else if (rd_idx == rx_cell_pkg::IDX_CTRL) begin
      rd_val = {2'b00, ctrl};
    end else if (rd_idx == rx_cell_pkg::IDX_IRQ_MASK) begin
      rd_val = {3'h0, irq_mask, 3'h0};
    end else begin
      rd_val = 8'h00;
      rd_hit = 1'b0;
    end
  end

  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;
  assign arready = !rvalid;

  // write channel capture and response
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 10'h000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= rx_cell_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? rx_cell_pkg::RESP_OKAY : rx_cell_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rx_cell_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_val};
      rresp <= rd_hit ? rx_cell_pkg::RESP_OKAY : rx_cell_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (reset) begin
      port_cfg <= 2'h0;
      period <= rx_cell_pkg::PERIOD_RESET;
      ctrl <= rx_cell_pkg::CTRL_RESET;
      irq_mask <= 2'h0;
    end else if (wr_en) begin
      if (wr_idx == rx_cell_pkg::IDX_PORT_CFG) begin
        port_cfg <= w_byte[1:0];
      end
      if (wr_idx == rx_cell_pkg::IDX_PERIOD) begin
        period <= w_byte;
      end
      if (wr_idx == rx_cell_pkg::IDX_CTRL) begin
        ctrl <= w_byte[5:0];
      end
      if (wr_idx == rx_cell_pkg::IDX_IRQ_MASK) begin
        irq_mask <= {w_byte[rx_cell_pkg::MASK_DELIN], w_byte[rx_cell_pkg::MASK_OVR]};
      end
    end
  end

  // status flags, a set in the clearing cycle survives
  wire [1:0] flag_set = {loss_toggle && irq_mask[1], overrun_evt && irq_mask[0]}; // [R13] [R14] [R24]

  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= 2'h0;
    end else begin
      flags <= (stat_rd ? 2'h0 : flags) | flag_set; // [R13] [R14]
    end
  end

  assign irq = |flags; // [R17]

  // live counters and their latches
  always_ff @(posedge clk) begin
    if (reset) begin
      corr_cnt <= 8'h00;
      unc_cnt <= 12'h000;
      acc_cnt <= 16'h0000;
      lat_corr <= 8'h00;
      lat_unc <= 12'h000;
      lat_acc <= 16'h0000;
    end else begin
      corr_cnt <= (latch_wr ? 8'h00 : corr_cnt) + {7'h00, corr_inc}; // [R6] [R8]
      unc_cnt <= (latch_wr ? 12'h000 : unc_cnt) + {8'h00, unc_inc}; // [R6] [R10]
      acc_cnt <= (latch_wr ? 16'h0000 : acc_cnt) + {15'h0000, acc_inc}; // [R6] [R12]
      if (latch_wr) begin
        lat_corr <= corr_cnt;
        lat_unc <= unc_cnt;
        lat_acc <= acc_cnt;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_good_presync;
    state == rx_cell_pkg::ST_PRESYNC && at_hdr && hec_ok && good_cnt == 3'h5;
  endsequence
  sequence s_in_sync;
    state == rx_cell_pkg::ST_SYNC && mode_corr;
  endsequence

  chk_zero_period: assert property ((period == 8'h00 && out_of_delineation && !cell_delineation_loss)
      |=> cell_delineation_loss) else $error("loss not declared at once with zero period"); // [R4]
  chk_counts_frozen: assert property ((state != rx_cell_pkg::ST_SYNC && !latch_wr)
      |=> $stable(corr_cnt) && $stable(unc_cnt) && $stable(acc_cnt)) else $error("counter moved out of sync"); // [R9]
  chk_latch_copy: assert property (latch_wr |=> lat_acc == $past(acc_cnt) && lat_unc == $past(unc_cnt)
      && acc_cnt == {15'h0000, $past(acc_inc)}) else $error("latch copy or clear wrong"); // [R6]
  chk_sync_exit: assert property ((leave_sync && corr_en && !latch_wr) |=> state == rx_cell_pkg::ST_HUNT
      && unc_cnt == $past(unc_cnt) + 12'h005 && corr_cnt == $past(corr_cnt) + 8'h01)
      else $error("sync exit tally wrong"); // [R10]
  chk_sync_entry: assert property (s_good_presync |=> s_in_sync) else $error("sync not entered"); // [R11]
  chk_overrun_flag: assert property ((overrun_evt && irq_mask[0]) |=> flags[0] && irq)
      else $error("overrun flag not set"); // [R13]
  chk_delin_flag: assert property ((loss_toggle && irq_mask[1]) |=> flags[1]
      && cell_delineation_loss != $past(cell_delineation_loss)) else $error("change flag not set"); // [R14]
  chk_irq_clear: assert property ((stat_rd && flag_set == 2'h0) |=> !irq) else $error("irq stuck after read"); // [R17]
  chk_buffer_cap: assert property ((want_cell && buf_full) |=> !wr_active && cell_count <= rx_cell_pkg::BUF_CELLS)
      else $error("cell written into full buffer"); // [R23]
  chk_poll_mode: assert property ((cell_count != 3'h0) |-> (single_cell_available != poll_sel)
      && (direct_cell_available == poll_sel)) else $error("poll signalling wrong"); // [R1]
endmodule

// file: src/rx_cell_pkg.sv
// Notes on behaviour
// R1 - poll bit: 0 shared cell flag, 1 direct
// R2 - declare loss after programmed out-of-delineation period
// R3 - clear loss after same period in sync
// R4 - period zero declares loss at once
// R5 - period unit 1 ms e1, 1.326 ms t1
// R6 - latch trigger write copies counts, clears live
// R7 - cell count latch readable at eight addresses
// R8 - correctable counts only with correction enabled, mode
// R9 - counters frozen outside sync
// R10 - sync exit adds 1+5, or 6 uncorrectable
// R11 - seventh consecutive bad header leaves sync
// R12 - cell count rises per buffered sync cell
// R13 - overrun flag bit 0, cleared by read
// R14 - delineation change flag bit 1, read-cleared
// R15 - loss bit and receiver mode bit encoding
// R16 - state field 00 hunt, 01 presync, 1x sync
// R17 - irq while any low status flag set
// R18 - remove 0x55 offset before check
// R19 - correct single-bit errors in correction mode only
// R20 - descramble payload x^43+1 in presync/sync
// R21 - forward good cells, or all in pass mode
// R22 - drop idle and unassigned cells when enabled
// R23 - four unread cells overrun, later cells dropped
// R24 - masks gate overrun and delineation flags
package rx_cell_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_PORT_CFG = 8'h60;
  localparam logic [7:0] IDX_PERIOD = 8'h61;
  localparam logic [7:0] IDX_LATCH = 8'h62;
  localparam logic [7:0] IDX_CORR = 8'h63;
  localparam logic [7:0] IDX_UNC_HI = 8'h64;
  localparam logic [7:0] IDX_UNC_LO = 8'h65;
  localparam logic [7:0] IDX_CELL_HI = 8'h66;
  localparam logic [7:0] IDX_CELL_LO = 8'h67;
  localparam logic [7:0] IDX_STATUS = 8'h68;
  localparam logic [7:0] IDX_CTRL = 8'h69;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h6A;
  localparam int ALIAS_BITS = 5;
  localparam int ADDR_W = 10;
  // reset values
  localparam logic [7:0] PERIOD_RESET = 8'h66;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  // field positions
  localparam int CFG_E1 = 0;
  localparam int CFG_POLL = 1;
  localparam int CTRL_CHECK_BYTE_OFFSET = 0;
  localparam int CTRL_CORR = 1;
  localparam int CTRL_DESCR = 2;
  localparam int CTRL_PASS = 3;
  localparam int CTRL_IDLE = 4;
  localparam int CTRL_UNAS = 5;
  localparam int MASK_OVR = 3;
  localparam int MASK_DELIN = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // cell format and delineation
  localparam logic [5:0] HDR_LAST = 6'h04;
  localparam logic [5:0] HDR_BYTES = 6'h05;
  localparam logic [5:0] CELL_LAST = 6'h34;
  localparam logic [2:0] DELTA = 3'h6;
  localparam logic [2:0] ALPHA_LAST = 3'h6;
  localparam logic [3:0] EXIT_UNC_CORR = 4'h5;
  localparam logic [3:0] EXIT_UNC_DET = 4'h6;
  localparam logic [2:0] BUF_CELLS = 3'h4;
  localparam logic [7:0] CHECK_BYTE_OFFSET = 8'h55;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [31:0] IDLE_HDR = 32'h0000_0001;
  localparam logic [31:0] UNAS_HDR = 32'h0000_0000;
  localparam int SCR_LEN = 43;
  // period unit timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int E1_UNIT_NS = 1000000;
  localparam int T1_UNIT_NS = 1326000;
  localparam int E1_UNIT_CYCLES = E1_UNIT_NS / (CLK_PERIOD_PS / 1000);
  localparam int T1_UNIT_CYCLES = T1_UNIT_NS / (CLK_PERIOD_PS / 1000);
  localparam int PRE_W = 20;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_PRESYNC = 2'b01,
    ST_SYNC = 2'b10
  } delin_state_t;

  // header check over 32 header bits, msb first
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // error mask of a single-bit error matching the syndrome, zero if none
  function automatic logic [39:0] fix_mask(input logic [7:0] syn);
    logic [39:0] m;
    m = '0;
    for (int j = 0; j < 32; j++) begin
      if (crc8(32'h0000_0001 << j) == syn) begin
        m[j + 8] = 1'b1;
      end
    end
    for (int k = 0; k < 8; k++) begin
      if ((8'h01 << k) == syn) begin
        m[k] = 1'b1;
      end
    end
    return m;
  endfunction
endpackage

// file: src/cell_payload_mem.sv
// payload store, four cells of 48 bytes, registered read data
module cell_payload_mem (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [256];

  // one write and one read per cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// file: test/cell_reader.sv
// far-side consumer pulling cell bytes with periodic stalls
module cell_reader (
  input wire logic clk,
  input wire logic take,
  input wire logic avail,
  output logic cell_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] slow = 2'b00;
  // pull while a cell waits, idle one cycle in four
  always @(posedge clk) begin
    slow <= slow + 2'b01;
    cell_rd <= take && avail && slow != 2'b11;
  end
endmodule

// file: test/atm_cell_receive_processor_tb.sv
module atm_cell_receive_processor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, line_clk = 0, take = 0;
  logic [9:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, seed = 32'h84e3_ef04;
  logic [7:0] line_data = '0, pl [48], q [$], m [$];
  logic [3:0] wstrb = 4'hf;
  wire awready, wready, bvalid, arready, rvalid, cell_rd, cell_valid, cell_start, cell_avail, direct_avail, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] cell_data;
  int n_fail = 0, check_count = 0, cyc = 0, nb = 0;

  rx_cell_processor #(.E1_UNIT_CYCLES(20), .T1_UNIT_CYCLES(27)) u_dut (.clk(clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_clk(line_clk),
    .line_data(line_data), .cell_rd(cell_rd), .cell_data(cell_data), .cell_valid(cell_valid),
    .cell_start(cell_start), .single_cell_available(cell_avail), .direct_cell_available(direct_avail), .irq(irq));
  cell_reader u_reader (.clk(clk), .take(take), .avail(cell_avail), .cell_rd(cell_rd));

  // clock and cycle ceiling
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      close_out();
    end
  end

  // compare each read word or cell byte with the oldest note
  always @(posedge clk) if ((rvalid && rready) || cell_valid) begin
    check_count++;
    if (q.size() == 0 || (((rvalid && rready) ? rdata[7:0] : cell_data) & m[0]) !== q[0]) begin
      n_fail++;
      $display("wrong value at %0t: unexpected data", $time);
    end
    if (q.size() != 0) begin
      void'(q.pop_front());
      void'(m.pop_front());
    end
  end

  // cell framing: start marks byte 0 of every 53, direct flag idle in shared mode
  always @(posedge clk) if (cell_valid) begin
    check_count++;
    if (cell_start !== (nb % 53 == 0) || direct_avail !== 1'b0) begin
      n_fail++;
      $display("wrong value at %0t: cell framing", $time);
    end
    nb++;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // header check byte with offset added
  function automatic logic [7:0] hec(input logic [31:0] d);
    logic [7:0] c = 8'h00;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c ^ 8'h55;
  endfunction

  function automatic logic [7:0] cbyte(input int n, input logic [31:0] h);
    return n < 4 ? h[31 - 8 * n -: 8] : n == 4 ? hec(h) : pl[n - 5];
  endfunction

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0000_00, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    check_count++;
    if (bresp !== r) begin
      n_fail++;
      $display("wrong value at %0t: write response", $time);
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [7:0] k);
    q.push_back(e & k);
    m.push_back(k);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    check_count++;
    if (rresp !== rx_cell_pkg::RESP_OKAY) begin
      n_fail++;
      $display("wrong value at %0t: read response", $time);
    end
    @(posedge clk);
  endtask

  // one cell on the link, x flips bits of the check byte
  task automatic send(input logic [31:0] h, input logic [7:0] x);
    for (int n = 0; n < 53; n++) begin
      line_data <= cbyte(n, h) ^ (n == 4 ? x : 8'h00);
      #62.5 line_clk <= 1'b1;
      #62.5 line_clk <= 1'b0;
    end
  endtask

  task automatic irq_is(input logic e);
    check_count++;
    if (irq !== e) begin
      n_fail++;
      $display("wrong value at %0t: interrupt level", $time);
    end
  endtask

  task close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial begin
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      pl[i] = seed[7:0];
    end
    repeat (4) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rd(rx_cell_pkg::IDX_PERIOD, 8'h66, 8'hff);
    rd(rx_cell_pkg::IDX_CTRL, 8'h01, 8'h3f);
    rd(rx_cell_pkg::IDX_STATUS, 8'h04, 8'h37);
    wr(8'h7f, 8'h00, rx_cell_pkg::RESP_SLVERR);
    wr(rx_cell_pkg::IDX_PERIOD, 8'h03, rx_cell_pkg::RESP_OKAY);
    wr(rx_cell_pkg::IDX_IRQ_MASK, 8'h18, rx_cell_pkg::RESP_OKAY);
    rd(rx_cell_pkg::IDX_PERIOD, 8'h03, 8'hff);
    repeat (12) send(32'h0012_3450, 8'h00);
    @(posedge clk);
    irq_is(1'b1);
    rd(rx_cell_pkg::IDX_STATUS, 8'h23, 8'h27);
    irq_is(1'b0);
    wr(rx_cell_pkg::IDX_LATCH, 8'h00, rx_cell_pkg::RESP_OKAY);
    rd(rx_cell_pkg::IDX_CELL_LO, 8'h04, 8'hff);
    rd(8'h87, 8'h04, 8'hff);
    rd(rx_cell_pkg::IDX_UNC_LO, 8'h00, 8'hff);
    for (int n = 0; n < 212; n++) q.push_back(cbyte(n % 53, 32'h0012_3450));
    for (int n = 0; n < 212; n++) m.push_back(8'hff);
    take <= 1;
    while (q.size() != 0) @(posedge clk);
    take <= 0;
    // one corrected cell, then seven errored headers drop sync
    wr(rx_cell_pkg::IDX_CTRL, 8'h03, rx_cell_pkg::RESP_OKAY);
    send(32'h0012_3450, 8'h01);
    repeat (7) send(32'h0012_3450, 8'hff);
    @(posedge clk);
    irq_is(1'b1);
    rd(rx_cell_pkg::IDX_STATUS, 8'h06, 8'h27);
    wr(rx_cell_pkg::IDX_LATCH, 8'h00, rx_cell_pkg::RESP_OKAY);
    rd(rx_cell_pkg::IDX_CORR, 8'h02, 8'hff);
    rd(rx_cell_pkg::IDX_UNC_LO, 8'h05, 8'hff);
    rd(rx_cell_pkg::IDX_CELL_LO, 8'h01, 8'hff);
    close_out();
  end
endmodule
